// file: logic/scf_defines.svh
/*
 * Constants of the subscriber-carrier superframe framer: frame geometry,
 * alignment pattern, overhead layout and reset values.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef SCF_DEFINES_SVH
`define SCF_DEFINES_SVH

// Bits in one basic frame: one overhead bit plus 24 channels of 8 bits
`define SCF_CHANNELS 24
`define SCF_CHANNEL_BITS 8
`define SCF_FRAME_BITS 193
// Last bit index inside a basic frame
`define SCF_LAST_BIT 8'h00_C0
// Superframe built from six twelve-frame superframes
`define SCF_SUB_SF 6
`define SCF_SUB_SF_FRAMES 12
// Frames in the whole superframe
`define SCF_SF_FRAMES 7'h48
// Alignment pattern over 24 overhead bits, earliest arrival in the MSB
`define SCF_PAT_LEN 24
`define SCF_PATTERN 24'h23_7237
// Frame whose overhead bit completes the pattern (frames 71..22 carry it)
`define SCF_LOCK_FRAME 7'h16
// Signalling-framing values of even frames 2..22, frame 2 in the MSB
`define SCF_SIG_PATTERN 11'h1C7
// Robbed-bit signalling repeats every six frames
`define SCF_ROBBED_PERIOD 7'h06
// Reset values
`define SCF_FRAME_RST 7'h00
`define SCF_BIT_RST 8'h00
`define SCF_HIST_RST 29'h0000_0000

`endif

// file: logic/scf_pkg.sv
/*
 * Types of the subscriber-carrier superframe framer.
 * Assumes scf_defines.svh is on the include path.
 */
`default_nettype none
`include "scf_defines.svh"

package scf_pkg;

    // Alignment state of the receive framer
    typedef enum logic [1:0] {
        SCF_CLEAR,
        SCF_SEARCH,
        SCF_LOCKED
    } scf_state_e;

    // Role of the overhead bit of a given frame
    typedef enum logic [3:0] {
        SCF_OH_NONE,
        SCF_OH_TERMINAL,
        SCF_OH_SIGNALLING,
        SCF_OH_CONCENTRATOR,
        SCF_OH_SPOILER,
        SCF_OH_MAINTENANCE,
        SCF_OH_ALARM,
        SCF_OH_SWITCH,
        SCF_OH_FIXED_ZERO
    } scf_oh_kind_e;

    // Robbed-bit signalling letter A..D
    typedef logic [1:0] scf_letter_t;

endpackage : scf_pkg

`default_nettype wire

// file: logic/scf_slot_decode.sv
/*
 * Combinational decode of one superframe frame number into the role of
 * its overhead bit, the fixed value that bit should carry, the field
 * number of a carried overhead bit and the robbed-bit signalling slot.
 * Assumes a frame number of 1..72; other values decode as no overhead.
 */
`default_nettype none
`include "scf_defines.svh"

module scf_slot_decode
    import scf_pkg::*;
(
    input wire logic [6:0] i_frame_number,
    output scf_oh_kind_e o_kind,
    output logic o_expected,
    output logic [3:0] o_field_index,
    output logic o_robbed,
    output scf_letter_t o_letter
);

    logic [5:0] half; // Pair number of an even frame
    logic [6:0] sixth; // Frame number divided by six
    logic [3:0] sig_idx; // Position in the signalling-framing sequence

    // Overhead role by frame position
    always_comb
    begin
        half = i_frame_number[6:1];
        sig_idx = 4'(half - 6'd1);
        o_kind = SCF_OH_NONE;
        o_expected = 1'b0;
        o_field_index = 4'h0;
        if (i_frame_number == 7'h00 || i_frame_number > `SCF_SF_FRAMES)
        begin
            o_kind = SCF_OH_NONE; // Outside the superframe
        end
        else if (i_frame_number[0])
        begin
            o_kind = SCF_OH_TERMINAL;
            o_expected = ~i_frame_number[1];
        end
        else if (half <= 6'd11)
        begin
            o_kind = SCF_OH_SIGNALLING;
            // Pick one bit of the sequence; the cast keeps only that bit
            o_expected = 1'((`SCF_SIG_PATTERN >> (4'd10 - sig_idx)) & 11'h001);
        end
        else if (half <= 6'd22)
        begin
            o_kind = SCF_OH_CONCENTRATOR;
            o_field_index = 4'(half - 6'd11);
        end
        else if (half <= 6'd25)
        begin
            o_kind = SCF_OH_SPOILER;
            o_expected = (half == 6'd24);
        end
        else if (half <= 6'd28)
        begin
            o_kind = SCF_OH_MAINTENANCE;
            o_field_index = 4'(half - 6'd25);
        end
        else if (half <= 6'd30)
        begin
            o_kind = SCF_OH_ALARM;
            o_field_index = 4'(half - 6'd28);
        end
        else if (half <= 6'd34)
        begin
            o_kind = SCF_OH_SWITCH;
            o_field_index = 4'(half - 6'd30);
        end
        else if (half == 6'd35)
        begin
            o_kind = SCF_OH_SPOILER;
            o_expected = 1'b1;
        end
        else
        begin
            o_kind = SCF_OH_FIXED_ZERO;
            o_expected = 1'b0;
        end
    end

    // Robbed-bit frames and their A, B, C, D letter
    always_comb
    begin
        sixth = 7'(i_frame_number / `SCF_ROBBED_PERIOD);
        o_robbed = (i_frame_number != 7'h00) && (i_frame_number <= `SCF_SF_FRAMES)
            && (7'(i_frame_number % `SCF_ROBBED_PERIOD) == 7'h00);
        o_letter = scf_letter_t'(sixth - 7'd1);
    end

endmodule : scf_slot_decode

`default_nettype wire

// file: logic/scf_framer.sv
/*
 * Receive alignment for the 72-frame subscriber-carrier superframe of a
 * T1 line. Searches all 193 bit positions for the 24-bit overhead
 * alignment pattern, locks, numbers frames and labels every received bit.
 * Assumes one received bit per i_rx_valid strobe, synchronous to i_clk,
 * already recovered from the line; no loss-of-alignment monitor here.
 */
// Summary of operation
// - Superframe is six twelve-frame superframes, 72 frames
// - Frame: one overhead bit, 24 eight-bit channels
// - Compare 24 overhead bits with fixed pattern
// - Declare sync on full pattern match
// - Frame carrying pattern's first one is frame 1
// - Out-of-frame flag low when synced, else high
// - Boundary flag at first bit of superframe
// - Odd frames carry alternating terminal framing bits
// - Even frames 2-22 signalling framing; 72 zero
// - Frames 24-44 carry eleven concentrator bits
// - Spoiler bits in frames 46, 48, 50, 70
// - Maintenance, alarm, switch bits in frames 52-68
// - Bit 8 robbed signalling every sixth frame
`default_nettype none
`include "scf_defines.svh"

module scf_framer
    import scf_pkg::*;
#(
    parameter int NUM_SUB_SF = `SCF_SUB_SF
)
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_rx_valid,
    input wire logic i_rx_bit,
    input wire logic i_reframe,
    output logic o_out_of_frame_flag,
    output logic o_superframe_boundary_flag,
    output logic o_bit_valid,
    output logic o_bit,
    output logic [6:0] o_frame_number,
    output logic [7:0] o_bit_index,
    output logic o_overhead,
    output scf_oh_kind_e o_overhead_kind,
    output logic o_overhead_expected,
    output logic [3:0] o_field_index,
    output logic o_signalling_bit,
    output scf_letter_t o_signalling_letter
);

    // Frames in one superframe as built from the sub-superframes
    localparam int SF_FRAMES = NUM_SUB_SF * `SCF_SUB_SF_FRAMES;

    // The overhead layout is fixed to six sub-superframes
    generate
        if (SF_FRAMES != int'(`SCF_SF_FRAMES))
        begin : g_bad_size
            $error("scf_framer supports only six sub-superframes");
        end
    endgenerate

    // Step a bit position round the 193-bit frame
    function automatic logic [7:0] next_pos(input logic [7:0] pos);
        next_pos = (pos == `SCF_LAST_BIT) ? 8'h00 : 8'(pos + 8'd1);
    endfunction : next_pos

    scf_state_e state_reg; // Alignment state
    logic [7:0] pos_reg; // Candidate position during clear and search
    logic [6:0] frame_reg; // Frame number once locked, 1..72
    logic [7:0] bit_reg; // Bit index inside the frame once locked, 0..192

    // History of each candidate position: fill count over 24 overhead bits
    logic [28:0] hist_mem [0:`SCF_FRAME_BITS-1];
    logic [28:0] hist_rd; // History at the current candidate
    logic [23:0] hist_new; // History with the arriving bit shifted in
    logic [4:0] fill_new; // Bits seen at this candidate, saturating
    logic pattern_hit; // Full alignment pattern seen at this candidate

    scf_oh_kind_e dec_kind; // Overhead role of the current frame
    logic dec_expected; // Fixed value of the current overhead bit
    logic [3:0] dec_field; // Field number of a carried overhead bit
    logic dec_robbed; // Current frame robs bit 8 of each channel
    scf_letter_t dec_letter; // Signalling letter of the current frame

    logic locked_bit; // Strobe of a bit while aligned
    logic first_of_frame; // Current bit is the overhead bit

    // Candidate history read, shift and match
    always_comb
    begin
        hist_rd = hist_mem[pos_reg];
        hist_new = {hist_rd[22:0], i_rx_bit};
        fill_new = (hist_rd[28:24] >= 5'(`SCF_PAT_LEN)) ? hist_rd[28:24] : 5'(hist_rd[28:24] + 5'd1);
        pattern_hit = (fill_new >= 5'(`SCF_PAT_LEN)) && (hist_new == `SCF_PATTERN);
    end

    assign locked_bit = i_rx_valid && (state_reg == SCF_LOCKED);
    assign first_of_frame = (bit_reg == 8'h00);

    // Overhead and signalling layout of the current frame
    scf_slot_decode u_decode (
        .i_frame_number(frame_reg),
        .o_kind(dec_kind),
        .o_expected(dec_expected),
        .o_field_index(dec_field),
        .o_robbed(dec_robbed),
        .o_letter(dec_letter)
    );

    // Alignment state: clear the history, search, then hold the lock
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            state_reg <= SCF_CLEAR;
        end
        else
        begin
            case (state_reg)
                SCF_CLEAR:
                begin
                    // Sweep done, start looking
                    if (pos_reg == `SCF_LAST_BIT)
                    begin
                        state_reg <= SCF_SEARCH;
                    end
                end
                SCF_SEARCH:
                begin
                    if (i_reframe)
                    begin
                        state_reg <= SCF_CLEAR;
                    end
                    else if (i_rx_valid && pattern_hit)
                    begin
                        state_reg <= SCF_LOCKED;
                    end
                end
                SCF_LOCKED:
                begin
                    // Only a forced reframe leaves the lock
                    if (i_reframe)
                    begin
                        state_reg <= SCF_CLEAR;
                    end
                end
                default:
                begin
                    state_reg <= SCF_CLEAR;
                end
            endcase
        end
    end

    // Candidate position: sweeps while clearing, follows the line while searching
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            pos_reg <= `SCF_BIT_RST;
        end
        else if (i_reframe && state_reg != SCF_CLEAR)
        begin
            pos_reg <= `SCF_BIT_RST; // Restart the sweep from the top
        end
        else if (state_reg == SCF_CLEAR)
        begin
            pos_reg <= next_pos(pos_reg);
        end
        else if (state_reg == SCF_SEARCH && i_rx_valid)
        begin
            pos_reg <= next_pos(pos_reg);
        end
    end

    // History store, written without reset; the clear sweep empties it
    always_ff @(posedge i_clk)
    begin
        if (state_reg == SCF_CLEAR)
        begin
            hist_mem[pos_reg] <= `SCF_HIST_RST;
        end
        else if (state_reg == SCF_SEARCH && i_rx_valid)
        begin
            hist_mem[pos_reg] <= {fill_new, hist_new};
        end
    end

    // Frame and bit numbering, loaded at the lock and run from then on
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || state_reg == SCF_CLEAR)
        begin
            frame_reg <= `SCF_FRAME_RST;
            bit_reg <= `SCF_BIT_RST;
        end
        else if (state_reg == SCF_SEARCH && i_rx_valid && pattern_hit)
        begin
            // Pattern ends in frame 22 when frame 1 holds its first one
            frame_reg <= `SCF_LOCK_FRAME;
            bit_reg <= 8'h01;
        end
        else if (locked_bit)
        begin
            bit_reg <= next_pos(bit_reg);
            if (bit_reg == `SCF_LAST_BIT)
            begin
                // Wrap after frame 72 back to frame 1
                frame_reg <= (frame_reg == `SCF_SF_FRAMES) ? 7'h01 : 7'(frame_reg + 7'd1);
            end
        end
    end

    // Alignment status flags
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_out_of_frame_flag <= 1'b1;
            o_superframe_boundary_flag <= 1'b0;
        end
        else
        begin
            o_out_of_frame_flag <= (state_reg != SCF_LOCKED);
            o_superframe_boundary_flag <= locked_bit && first_of_frame && (frame_reg == 7'h01);
        end
    end

    // Labelled bit stream
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_bit_valid <= 1'b0;
            o_bit <= 1'b0;
            o_frame_number <= `SCF_FRAME_RST;
            o_bit_index <= `SCF_BIT_RST;
            o_overhead <= 1'b0;
            o_overhead_kind <= SCF_OH_NONE;
            o_overhead_expected <= 1'b0;
            o_field_index <= 4'h0;
            o_signalling_bit <= 1'b0;
            o_signalling_letter <= 2'h0;
        end
        else
        begin
            o_bit_valid <= i_rx_valid;
            o_bit <= i_rx_bit;
            o_frame_number <= locked_bit ? frame_reg : `SCF_FRAME_RST;
            o_bit_index <= locked_bit ? bit_reg : `SCF_BIT_RST;
            o_overhead <= locked_bit && first_of_frame;
            // Overhead labels only on the overhead bit
            if (locked_bit && first_of_frame)
            begin
                o_overhead_kind <= dec_kind;
                o_overhead_expected <= dec_expected;
                o_field_index <= dec_field;
            end
            else
            begin
                o_overhead_kind <= SCF_OH_NONE;
                o_overhead_expected <= 1'b0;
                o_field_index <= 4'h0;
            end
            // Bit 8 of every channel in the robbed frames
            o_signalling_bit <= locked_bit && dec_robbed && !first_of_frame && (bit_reg[2:0] == 3'h0);
            o_signalling_letter <= dec_robbed ? dec_letter : 2'h0;
        end
    end

endmodule : scf_framer

`default_nettype wire

// file: bench/scf_framer_props.sv
/*
 * Concurrent checks on the outputs of the subscriber-carrier framer.
 * Assumes it is bound to scf_framer and sees only that module's ports.
 */
`default_nettype none

module scf_framer_props
    import scf_pkg::*;
#(
    parameter int NUM_SUB_SF = 6
)
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_reframe,
    input wire logic o_out_of_frame_flag,
    input wire logic o_superframe_boundary_flag,
    input wire logic o_bit_valid,
    input wire logic [6:0] o_frame_number,
    input wire logic [7:0] o_bit_index,
    input wire logic o_overhead,
    input wire scf_oh_kind_e o_overhead_kind,
    input wire logic o_overhead_expected,
    input wire logic [3:0] o_field_index,
    input wire logic o_signalling_bit,
    input wire scf_letter_t o_signalling_letter
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    logic [6:0] last_frm; // Frame of the previous labelled bit
    logic [7:0] last_idx; // Index of the previous labelled bit
    logic last_ok; // Previous labelled bit was aligned
    logic aligned; // Current bit carries aligned labels
    assign aligned = o_bit_valid && !o_out_of_frame_flag;

    // Remember the last labelled position for the stepping check
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            last_ok <= 1'b0;
        end
        else if (o_bit_valid)
        begin
            last_ok <= !o_out_of_frame_flag;
            last_frm <= o_frame_number;
            last_idx <= o_bit_index;
        end
    end

    reset_out_a: assert property (!$past(i_rstn) |-> o_out_of_frame_flag && !o_bit_valid)
        else $error("outputs not at reset values");
    unaligned_zero_a: assert property (o_out_of_frame_flag |-> o_frame_number == 7'h00 && !o_overhead
        && !o_superframe_boundary_flag && !o_signalling_bit) else $error("labels shown while unaligned");
    oof_rise_a: assert property ($rose(o_out_of_frame_flag) |-> $past(i_reframe, 2))
        else $error("alignment lost without reframe");
    frame_range_a: assert property (aligned |-> o_frame_number >= 7'h01 && o_frame_number <= NUM_SUB_SF * 12
        && o_bit_index <= 8'h00_C0 && o_overhead == (o_bit_index == 8'h00)) else $error("position out of range");
    frame_step_a: assert property (aligned && last_ok |-> (last_idx == 8'h00_C0)
        ? (o_bit_index == 8'h00 && o_frame_number == (last_frm == 7'h48 ? 7'h01 : last_frm + 7'h01))
        : (o_bit_index == last_idx + 8'h01 && o_frame_number == last_frm)) else $error("position did not step");
    boundary_place_a: assert property (o_superframe_boundary_flag |-> aligned
        && o_frame_number == 7'h01 && o_bit_index == 8'h00) else $error("boundary flag misplaced");
    boundary_seen_a: assert property (aligned && o_frame_number == 7'h01 && o_overhead
        |-> o_superframe_boundary_flag) else $error("boundary flag missing");
    terminal_bit_a: assert property (aligned && o_overhead && o_frame_number[0]
        |-> o_overhead_kind == SCF_OH_TERMINAL && o_overhead_expected == !o_frame_number[1])
        else $error("terminal framing bit wrong");
    last_zero_a: assert property (aligned && o_overhead && o_frame_number == 7'h48
        |-> o_overhead_kind == SCF_OH_FIXED_ZERO && !o_overhead_expected) else $error("frame 72 bit wrong");
    payload_none_a: assert property (o_bit_valid && !o_overhead
        |-> o_overhead_kind == SCF_OH_NONE && o_field_index == 4'h0) else $error("payload bit has a role");
    robbed_slot_a: assert property (o_signalling_bit |-> aligned && o_frame_number % 7'h06 == 7'h00
        && o_bit_index[2:0] == 3'h0 && o_bit_index != 8'h00
        && o_signalling_letter == 2'(o_frame_number / 7'h06 - 7'h01)) else $error("robbed bit misplaced");

endmodule : scf_framer_props

`default_nettype wire

// file: bench/scf_line_model.sv
/*
 * Remote line terminal: sends 72-frame superframes one bit per strobe.
 * Assumes the receiver takes a bit on each rising edge with valid high.
 */
`default_nettype none

module scf_line_model
#(
    parameter logic CARRIED_BIT = 1'b1
)
(
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic i_slow,
    output logic o_valid,
    output logic o_bit,
    output logic [6:0] o_frame,
    output logic [7:0] o_index
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [6:0] frm = 7'h47; // Start at frame 71 so the pattern comes early
    logic [7:0] idx = 8'h00; // Bit position inside the frame
    logic gap = 1'b0; // Idle cycle due in slow mode

    // Overhead bit of a frame; frames 71..22 form the alignment pattern
    function automatic logic fbit(input logic [6:0] f);
        logic [10:0] sig;
        sig = 11'h1C7;
        if (f[0])
            return !f[1];
        if (f <= 7'h16)
            return sig[(7'h16 - f) >> 1];
        if (f == 7'h30 || f == 7'h46)
            return 1'b1;
        if (f == 7'h2E || f == 7'h32 || f == 7'h48)
            return 1'b0;
        return CARRIED_BIT;
    endfunction : fbit

    initial
    begin
        o_valid = 1'b0;
        o_bit = 1'b0;
        o_frame = 7'h00;
        o_index = 8'h00;
    end

    // One bit per cycle, or every other cycle when slow
    always @(posedge i_clk)
    begin
        #1;
        if (!i_run || (i_slow && gap))
        begin
            o_valid = 1'b0;
            o_bit = !o_bit; // Idle line shows no stale value
            gap = 1'b0;
        end
        else
        begin
            o_valid = 1'b1;
            o_frame = frm;
            o_index = idx;
            if (idx == 8'h00)
                o_bit = fbit(frm);
            else if (frm % 7'h06 == 7'h00 && idx[2:0] == 3'h0)
                o_bit = idx[3];
            else
                o_bit = 1'b1;
            gap = 1'b1;
            idx = (idx == 8'h00_C0) ? 8'h00 : idx + 8'h01;
            if (idx == 8'h00)
                frm = (frm == 7'h48) ? 7'h01 : frm + 7'h01;
        end
    end

endmodule : scf_line_model

`default_nettype wire

// file: bench/testbench.sv
/*
 * Self-checking bench of the framer: locks, labels a superframe, reframes
 * on a slowed stream and resets mid-run. Assumes the line model and checker.
 */
`default_nettype none

module testbench
    import scf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 90000; // Cycle ceiling for the whole run
    typedef struct { int lo; int hi; scf_oh_kind_e k; logic cnt; } scf_row_s;
    // Overhead rows: frames, role, whether the bits are a numbered field
    scf_row_s rows [9] = '{'{1, 71, SCF_OH_TERMINAL, 1'b0}, '{2, 22, SCF_OH_SIGNALLING, 1'b0},
        '{24, 44, SCF_OH_CONCENTRATOR, 1'b1}, '{46, 50, SCF_OH_SPOILER, 1'b0}, '{70, 70, SCF_OH_SPOILER, 1'b0},
        '{52, 56, SCF_OH_MAINTENANCE, 1'b1}, '{58, 60, SCF_OH_ALARM, 1'b1}, '{62, 68, SCF_OH_SWITCH, 1'b1},
        '{72, 72, SCF_OH_FIXED_ZERO, 1'b0}};
    scf_oh_kind_e ek [1:72]; // Expected role per frame
    logic [3:0] ef [1:72]; // Expected field number per frame
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic reframe = 1'b0;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic chk_on = 1'b0; // Per-bit monitor enabled
    logic m_valid, m_bit, oof, sfb, bval, obit, ovh, oexp, sigb;
    logic [6:0] m_frame, frm;
    logic [7:0] m_index, bidx;
    logic [3:0] fld;
    scf_oh_kind_e kind;
    scf_letter_t letter;
    logic pv = 1'b0; // Bit sent last cycle, as the outputs should show it
    logic pb = 1'b0;
    logic [6:0] pf = 7'h00;
    logic [7:0] pi = 8'h00;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    scf_line_model u_line(.i_clk(clk), .i_run(run), .i_slow(slow), .o_valid(m_valid), .o_bit(m_bit),
        .o_frame(m_frame), .o_index(m_index));
    scf_framer dut(.i_clk(clk), .i_rstn(rstn), .i_rx_valid(m_valid), .i_rx_bit(m_bit), .i_reframe(reframe),
        .o_out_of_frame_flag(oof), .o_superframe_boundary_flag(sfb), .o_bit_valid(bval), .o_bit(obit),
        .o_frame_number(frm), .o_bit_index(bidx), .o_overhead(ovh), .o_overhead_kind(kind),
        .o_overhead_expected(oexp), .o_field_index(fld), .o_signalling_bit(sigb), .o_signalling_letter(letter));

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic cmp_k(input scf_oh_kind_e e, input scf_oh_kind_e g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD kind expected %h seen %h", e, g);
        end
    endtask : cmp_k

    task automatic print_verdict();
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // Wait a bounded time for the out-of-frame flag to reach a level
    task automatic wait_oof(input logic v, input int maxc);
        int n;
        n = 0;
        while (oof !== v && n < maxc)
        begin
            @(posedge clk);
            #2;
            n++;
        end
        chk("oof", {7'h00, v}, {7'h00, oof});
    endtask : wait_oof

    // Fixed value of an overhead bit; carried fields read as zero
    function automatic logic exp_val(input logic [6:0] f);
        logic [10:0] sig;
        sig = 11'h1C7;
        if (f[0])
            return !f[1];
        if (f <= 7'h16)
            return sig[(7'h16 - f) >> 1];
        return f == 7'h30 || f == 7'h46;
    endfunction : exp_val

    // Compare every labelled bit with the position sent one cycle earlier
    always @(posedge clk)
    begin
        #2;
        cycles++;
        if (chk_on)
        begin
            chk("valid", {7'h00, pv}, {7'h00, bval});
            if (bval === 1'b1)
                chk("bit", {7'h00, pb}, {7'h00, obit});
            if (oof === 1'b1)
                chk("unaligned frame", 8'h00, {1'b0, frm});
            else if (bval === 1'b1)
            begin
                chk("frame", {1'b0, pf}, {1'b0, frm});
                chk("index", pi, bidx);
                chk("boundary", {7'h00, pf == 7'h01 && pi == 8'h00}, {7'h00, sfb});
                chk("overhead", {7'h00, pi == 8'h00}, {7'h00, ovh});
                if (pi == 8'h00)
                begin
                    cmp_k(ek[pf], kind);
                    chk("expected", {7'h00, exp_val(pf)}, {7'h00, oexp});
                    chk("field", {4'h0, ef[pf]}, {4'h0, fld});
                end
                chk("robbed", {7'h00, pf % 7'h06 == 7'h00 && pi != 8'h00 && pi[2:0] == 3'h0}, {7'h00, sigb});
                if (sigb === 1'b1)
                    chk("letter", {6'h00, 2'(pf / 7'h06 - 7'h01)}, {6'h00, letter});
            end
        end
        pv = m_valid;
        pb = m_bit;
        pf = m_frame;
        pi = m_index;
        if (cycles == LIMIT)
        begin
            miscompares++;
            print_verdict();
        end
    end

    initial
    begin
        for (int r = 0; r < 9; r++)
            for (int f = rows[r].lo; f <= rows[r].hi; f += 2)
            begin
                ek[f] = rows[r].k;
                ef[f] = rows[r].cnt ? 4'((f - rows[r].lo) / 2 + 1) : 4'h0;
            end
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        @(posedge clk);
        #2 chk("reset oof", 8'h01, {7'h00, oof});
        chk("reset frame", 8'h00, {1'b0, frm});
        chk_on = 1'b1;
        repeat (192) @(posedge clk);
        #1 run = 1'b1;
        wait_oof(1'b0, 100 * 193);
        repeat (72 * 193 + 200) @(posedge clk);
        // Reframe while locked, then relock on a stream with gaps
        #1 reframe = 1'b1;
        slow = 1'b1;
        @(posedge clk);
        #1 reframe = 1'b0;
        wait_oof(1'b1, 3);
        wait_oof(1'b0, 110 * 386);
        repeat (2000) @(posedge clk);
        // Reset in mid-stream
        #1 rstn = 1'b0;
        chk_on = 1'b0;
        run = 1'b0;
        repeat (12) @(posedge clk);
        #2 chk("mid reset oof", 8'h01, {7'h00, oof});
        chk("mid reset valid", 8'h00, {7'h00, bval});
        // Release the mid-run reset and watch the first two edges
        @(posedge clk);
        #1 rstn = 1'b1;
        @(posedge clk);
        #2 chk("release oof", 8'h01, {7'h00, oof});
        chk("release frame", 8'h00, {1'b0, frm});
        @(posedge clk);
        #2 chk("release valid", 8'h00, {7'h00, bval});
        chk("release oof 2", 8'h01, {7'h00, oof});
        print_verdict();
    end

endmodule : testbench

bind scf_framer scf_framer_props #(.NUM_SUB_SF(NUM_SUB_SF)) u_props(.i_clk(i_clk), .i_rstn(i_rstn),
    .i_reframe(i_reframe), .o_out_of_frame_flag(o_out_of_frame_flag),
    .o_superframe_boundary_flag(o_superframe_boundary_flag), .o_bit_valid(o_bit_valid),
    .o_frame_number(o_frame_number), .o_bit_index(o_bit_index), .o_overhead(o_overhead),
    .o_overhead_kind(o_overhead_kind), .o_overhead_expected(o_overhead_expected),
    .o_field_index(o_field_index), .o_signalling_bit(o_signalling_bit),
    .o_signalling_letter(o_signalling_letter));

`default_nettype wire
